/* File: core/bbp_pkg.sv */
// package: register map, reset values, opcodes, instruction classes and carriers
package bbp_pkg;

	// special function register map and reset values
	localparam logic [7:0] BBP_SP_ADDR      = 8'h81;
	localparam logic [7:0] BBP_DPL_ADDR     = 8'h82;
	localparam logic [7:0] BBP_DPH_ADDR     = 8'h83;
	localparam logic [7:0] BBP_SP_RST       = 8'h07;
	localparam logic [7:0] BBP_DPL_RST      = 8'h00;
	localparam logic [7:0] BBP_DPH_RST      = 8'h00;
	localparam logic [7:0] BBP_BITBYTE_BASE = 8'h20;
	localparam logic [15:0] BBP_PC_RST      = 16'h0000;

	// opcodes compared in full to select a variant inside a class
	localparam logic [7:0] BBP_OP_CLR_C   = 8'hC3;
	localparam logic [7:0] BBP_OP_BIT_SET_OP_C  = 8'hD3;
	localparam logic [7:0] BBP_OP_CLR_B   = 8'hC2;
	localparam logic [7:0] BBP_OP_BIT_SET_OP_B  = 8'hD2;
	localparam logic [7:0] BBP_OP_ANL_CB  = 8'h82;
	localparam logic [7:0] BBP_OP_ANL_CNB = 8'hB0;
	localparam logic [7:0] BBP_OP_ORL_CB  = 8'h72;
	localparam logic [7:0] BBP_OP_ORL_CNB = 8'hA0;
	localparam logic [7:0] BBP_OP_JNC     = 8'h50;
	localparam logic [7:0] BBP_OP_JNB     = 8'h30;
	localparam logic [7:0] BBP_OP_JBC     = 8'h10;
	localparam logic [7:0] BBP_OP_JNZ     = 8'h70;
	localparam logic [7:0] BBP_OP_CJ_ADIR = 8'hB5;

	// instruction classes seen by the sequencer
	typedef enum logic [4:0] {
		BBP_C_NOP, BBP_C_CBIT, BBP_C_BITMOD, BBP_C_BITC, BBP_C_MOVBC,
		BBP_C_JCY, BBP_C_JACC, BBP_C_JBIT, BBP_C_SHORT_RELATIVE_JUMP, BBP_C_PAGED_JUMP,
		BBP_C_PAGED_CALL, BBP_C_LONG_JUMP, BBP_C_LONG_CALL, BBP_C_RET, BBP_C_JIDX,
		BBP_C_CJA, BBP_C_CJR, BBP_C_CJI, BBP_C_DJR, BBP_C_DJD,
		BBP_C_PUSH, BBP_C_POP, BBP_C_NIBBLE_EXCHANGE, BBP_C_OTHER
	} bbp_cls_t;

	// decoded length in bytes and cycle count when no branch is taken
	typedef struct packed {
		bbp_cls_t   cls;
		logic [1:0] len;
		logic [2:0] ncyc;
	} bbp_dec_t;

	// data memory write carrier; ind marks an indirect (upper ram) access
	typedef struct packed {
		logic       we;
		logic       ind;
		logic [7:0] addr;
		logic [7:0] data;
	} bbp_wr_t;

endpackage

/* File: core/bbp_decode.sv */
// opcode decoder: instruction class, byte length and base cycle count
`timescale 1ns/1ps
module bbp_decode import bbp_pkg::*; (
	input  wire logic [7:0] op_i,
	output bbp_dec_t        dec_o
);

	// one table entry per opcode group
	always_comb begin
		dec_o = '{cls: BBP_C_OTHER, len: 2'd1, ncyc: 3'd1};
		casez (op_i)
			8'h00, 8'hA5:             dec_o = '{BBP_C_NOP, 2'd1, 3'd1};
			8'hC3, 8'hD3, 8'hB3:      dec_o = '{BBP_C_CBIT, 2'd1, 3'd1};
			8'hC2, 8'hD2, 8'hB2:      dec_o = '{BBP_C_BITMOD, 2'd2, 3'd2};
			8'h82, 8'hB0, 8'h72,
			8'hA0, 8'hA2:             dec_o = '{BBP_C_BITC, 2'd2, 3'd2};
			8'h92:                    dec_o = '{BBP_C_MOVBC, 2'd2, 3'd2};
			8'h40, 8'h50:             dec_o = '{BBP_C_JCY, 2'd2, 3'd2};
			8'h60, 8'h70:             dec_o = '{BBP_C_JACC, 2'd2, 3'd2};
			8'h20, 8'h30, 8'h10:      dec_o = '{BBP_C_JBIT, 2'd3, 3'd3};
			8'h80:                    dec_o = '{BBP_C_SHORT_RELATIVE_JUMP, 2'd2, 3'd3};
			8'b???0_0001:             dec_o = '{BBP_C_PAGED_JUMP, 2'd2, 3'd3};
			8'b???1_0001:             dec_o = '{BBP_C_PAGED_CALL, 2'd2, 3'd3};
			8'h02:                    dec_o = '{BBP_C_LONG_JUMP, 2'd3, 3'd4};
			8'h12:                    dec_o = '{BBP_C_LONG_CALL, 2'd3, 3'd4};
			8'h22, 8'h32:             dec_o = '{BBP_C_RET, 2'd1, 3'd5};
			8'h73:                    dec_o = '{BBP_C_JIDX, 2'd1, 3'd3};
			8'hB4, 8'hB5:             dec_o = '{BBP_C_CJA, 2'd3, 3'd3};
			8'b1011_1???:             dec_o = '{BBP_C_CJR, 2'd3, 3'd3};
			8'hB6, 8'hB7:             dec_o = '{BBP_C_CJI, 2'd3, 3'd4};
			8'b1101_1???:             dec_o = '{BBP_C_DJR, 2'd2, 3'd2};
			8'hD5:                    dec_o = '{BBP_C_DJD, 2'd3, 3'd3};
			8'hC0:                    dec_o = '{BBP_C_PUSH, 2'd2, 3'd2};
			8'hD0:                    dec_o = '{BBP_C_POP, 2'd2, 3'd2};
			8'hD6, 8'hD7:             dec_o = '{BBP_C_NIBBLE_EXCHANGE, 2'd1, 3'd3};
			default:                  dec_o = '{BBP_C_OTHER, 2'd1, 3'd1};
		endcase
	end

endmodule

/* File: core/bbp_core.sv */
// bit, branch and pointer register execution core
//
// How it works
// [RULE_01] and/or a direct bit or its complement into carry: 2 bytes, 2 cycles
// [RULE_02] move bit to carry, carry to bit, clear/set/flip bit: 2 bytes, 2 cycles
// [RULE_03] branch on carry high/low: 2 bytes, 2 cycles, 3 when taken
// [RULE_04] bit branches: 3 bytes, 3 or 4 cycles; branch-and-clear clears set bit
// [RULE_05] paged call/jump use 11-bit target inside next instruction's 2 kB page
// [RULE_06] long call/jump: 3 bytes, 4 cycles, 16-bit target anywhere
// [RULE_07] signed 8-bit offset added to address after branch; short jump 2/3
// [RULE_08] indexed jump goes to accumulator plus data pointer: 1 byte, 3 cycles
// [RULE_09] branch on accumulator zero/nonzero: 2 bytes, 2 or 3 cycles
// [RULE_10] compare-branch 3 bytes; 3/4 cycles, indirect form 4/5 cycles
// [RULE_11] decrement-branch: register form 2 bytes 2/3, direct form 3 bytes 3/4
// [RULE_12] opcode A5 acts as the 1-byte 1-cycle no-operation
// [RULE_13] bank register operand picks R0..R7 of the selected bank
// [RULE_14] indirect operand takes its address from R0 or R1 of current bank
// [RULE_15] direct address below 0x80 is data ram, above is special register
// [RULE_16] data pointer pair is low byte 0x82, high byte 0x83, reset zero
// [RULE_17] stack pointer at 0x81 resets to 0x07, incremented before push write
// [RULE_18] nibble exchange swaps low nibbles of accumulator and indirect byte
// [RULE_19] push is 2 bytes, 2 cycles, stores direct byte at incremented pointer
// [RULE_20] carry clear/set/flip take 1 byte, 1 cycle; no-operation changes nothing
// [RULE_21] returns pop program counter, pointer decrements per byte after read
`timescale 1ns/1ps
module bbp_core import bbp_pkg::*; (
	input  wire logic        REF_CLK_I,
	input  wire logic        RST_N_I,
	input  wire logic [7:0]  CODE_DATA_I,
	output logic [15:0]      CODE_ADDR_O,
	input  wire logic [7:0]  DATA_RDATA_I,
	output logic [7:0]       DATA_RADDR_O,
	output logic             DATA_RIND_O,
	output bbp_wr_t          DATA_WR_O,
	input  wire logic [7:0]  ACC_I,
	input  wire logic        CARRY_I,
	input  wire logic [1:0]  BANK_SEL_I,
	output logic             CARRY_WE_O,
	output logic             CARRY_O,
	output logic             ACC_WE_O,
	output logic [7:0]       ACC_O,
	output logic [7:0]       STACK_PTR_O,
	output logic [15:0]      DATA_POINTER_PAIR_O,
	output logic             FETCH_O,
	output logic             UNKNOWN_OP_O
);

	////////////////////////////////////////////////////////////////////////
	// state and working signals

	logic [15:0] pc_r;
	logic [2:0]  cyc_r;
	logic [7:0]  opc_r;
	logic [7:0]  op1_r;
	logic [7:0]  op2_r;
	logic [7:0]  rd_r;
	logic [7:0]  sp_r;
	logic [7:0]  dpl_r;
	logic [7:0]  dph_r;
	logic        fetch_r;
	logic        unknown_r;

	logic [7:0]  op;
	bbp_dec_t    dec;
	logic        in_fetch;
	logic [15:0] pcn;
	logic [7:0]  rel_b;
	logic [15:0] rel_tgt;
	logic [7:0]  ba;
	logic [7:0]  bb;
	logic [7:0]  mask;
	logic [7:0]  bank_addr;
	logic [7:0]  ptr_addr;
	logic [7:0]  raddr;
	logic        rind;
	logic [7:0]  rval;
	logic        bv;
	logic [7:0]  dec_v;

	bbp_wr_t     wr;
	logic        carry_we;
	logic        carry_v;
	logic        acc_we;
	logic [7:0]  acc_v;
	logic        taken;
	logic        pc_ld;
	logic [15:0] tgt;
	logic [7:0]  sp_nxt;
	logic        int_hit;
	logic        last;

	////////////////////////////////////////////////////////////////////////
	// decode

	// opcode straight off the code bus in the first cycle so 1-cycle ops fit
	assign op = (cyc_r == 3'd0) ? CODE_DATA_I : opc_r;

	bbp_decode u_decode (
		.op_i  (op),
		.dec_o (dec)
	);

	// operand fetch runs while the cycle index is below the length
	assign in_fetch = (cyc_r < {1'b0, dec.len});
	assign pcn      = pc_r + 16'h0001;

	// offset counts from the byte after the instruction
	assign rel_b   = in_fetch ? CODE_DATA_I : op2_r;
	assign rel_tgt = (in_fetch ? pcn : pc_r) + {{8{rel_b[7]}}, rel_b}; // [RULE_07]

	// bit address: taken live in cycle 1, from the latched operand later
	assign ba   = (cyc_r == 3'd1) ? CODE_DATA_I : op1_r;
	assign bb   = ba[7] ? {ba[7:3], 3'b000} : BBP_BITBYTE_BASE + {4'h0, ba[6:3]}; // [RULE_15]
	assign mask = 8'h01 << ba[2:0];

	// register operands live in the selected bank
	assign bank_addr = {3'b000, BANK_SEL_I, op[2:0]}; // [RULE_13]
	assign ptr_addr  = {3'b000, BANK_SEL_I, 2'b00, op[0]}; // [RULE_14]

	////////////////////////////////////////////////////////////////////////
	// read address, kept apart from the execute block to avoid a false loop

	always_comb begin
		raddr = 8'h00;
		rind  = 1'b0;
		case (dec.cls)
			BBP_C_BITMOD, BBP_C_BITC, BBP_C_MOVBC, BBP_C_JBIT: raddr = bb;
			BBP_C_CJA:        raddr = op1_r;
			BBP_C_DJD:        raddr = op1_r;
			BBP_C_PUSH:       raddr = CODE_DATA_I;
			BBP_C_CJR, BBP_C_DJR: raddr = bank_addr;
			BBP_C_POP, BBP_C_RET: begin
				raddr = sp_r;
				rind  = 1'b1;
			end
			BBP_C_CJI, BBP_C_NIBBLE_EXCHANGE: begin
				raddr = (cyc_r == 3'd1) ? ptr_addr : rd_r;
				rind  = (cyc_r != 3'd1);
			end
			default:          raddr = 8'h00;
		endcase
	end

	// own registers answer their direct addresses, the rest comes from outside
	always_comb begin
		if (!rind && raddr == BBP_SP_ADDR) begin
			rval = sp_r;
		end else if (!rind && raddr == BBP_DPL_ADDR) begin
			rval = dpl_r;
		end else if (!rind && raddr == BBP_DPH_ADDR) begin
			rval = dph_r;
		end else begin
			rval = DATA_RDATA_I;
		end
	end

	assign bv    = rval[ba[2:0]];
	assign dec_v = rval - 8'h01;

	////////////////////////////////////////////////////////////////////////
	// execute: one case item per class, NOP and OTHER sharing the default; each multi-cycle class gated by its working cycle

	always_comb begin
		wr       = '0;
		carry_we = 1'b0;
		carry_v  = CARRY_I;
		acc_we   = 1'b0;
		acc_v    = ACC_I;
		taken    = 1'b0;
		pc_ld    = 1'b0;
		tgt      = rel_tgt;
		sp_nxt   = sp_r;
		case (dec.cls)
			BBP_C_CBIT: begin
				carry_we = 1'b1; // [RULE_20]
				if (op == BBP_OP_CLR_C) begin
					carry_v = 1'b0;
				end else if (op == BBP_OP_BIT_SET_OP_C) begin
					carry_v = 1'b1;
				end else begin
					carry_v = ~CARRY_I;
				end
			end
			BBP_C_BITMOD: begin
				// only the operand cycle holds a valid bit address; cycle 0 would hit a stale byte
				if (cyc_r == 3'd1) begin
					wr = '{1'b1, 1'b0, bb, rval ^ mask}; // [RULE_02]
					if (op == BBP_OP_CLR_B) begin
						wr.data = rval & ~mask;
					end else if (op == BBP_OP_BIT_SET_OP_B) begin
						wr.data = rval | mask;
					end
				end
			end
			BBP_C_BITC: begin
				carry_we = (cyc_r == 3'd1); // [RULE_01]
				if (op == BBP_OP_ANL_CB) begin
					carry_v = CARRY_I & bv;
				end else if (op == BBP_OP_ANL_CNB) begin
					carry_v = CARRY_I & ~bv;
				end else if (op == BBP_OP_ORL_CB) begin
					carry_v = CARRY_I | bv;
				end else if (op == BBP_OP_ORL_CNB) begin
					carry_v = CARRY_I | ~bv;
				end else begin
					carry_v = bv; // [RULE_02]
				end
			end
			BBP_C_MOVBC: begin
				if (cyc_r == 3'd1) begin
					wr = '{1'b1, 1'b0, bb, (rval & ~mask) | (CARRY_I ? mask : 8'h00)}; // [RULE_02]
				end
			end
			BBP_C_JCY: begin
				if (cyc_r == 3'd1) begin
					taken = CARRY_I ^ (op == BBP_OP_JNC); // [RULE_03]
				end
			end
			BBP_C_JACC: begin
				if (cyc_r == 3'd1) begin
					taken = (ACC_I == 8'h00) ^ (op == BBP_OP_JNZ); // [RULE_09]
				end
			end
			BBP_C_JBIT: begin
				if (cyc_r == 3'd2) begin
					taken = bv ^ (op == BBP_OP_JNB); // [RULE_04]
					// clear only when the set bit actually caused the branch
					if (op == BBP_OP_JBC && taken) begin
						wr = '{1'b1, 1'b0, bb, rval & ~mask}; // [RULE_04]
					end
				end
			end
			BBP_C_SHORT_RELATIVE_JUMP: begin
				pc_ld = (cyc_r == 3'd1); // [RULE_07]
			end
			BBP_C_PAGED_JUMP: begin
				pc_ld = (cyc_r == 3'd1);
				tgt   = {pcn[15:11], op[7:5], CODE_DATA_I}; // [RULE_05]
			end
			BBP_C_PAGED_CALL: begin
				// low return byte first, high byte and jump one cycle later
				if (cyc_r == 3'd1) begin
					sp_nxt = sp_r + 8'h01;
					wr     = '{1'b1, 1'b1, sp_nxt, pcn[7:0]};
				end else if (cyc_r == 3'd2) begin
					sp_nxt = sp_r + 8'h01;
					wr     = '{1'b1, 1'b1, sp_nxt, pc_r[15:8]};
					pc_ld  = 1'b1;
					tgt    = {pc_r[15:11], op[7:5], op1_r}; // [RULE_05]
				end
			end
			BBP_C_LONG_JUMP: begin
				pc_ld = (cyc_r == 3'd2);
				tgt   = {op1_r, CODE_DATA_I}; // [RULE_06]
			end
			BBP_C_LONG_CALL: begin
				if (cyc_r == 3'd2) begin
					sp_nxt = sp_r + 8'h01;
					wr     = '{1'b1, 1'b1, sp_nxt, pcn[7:0]};
				end else if (cyc_r == 3'd3) begin
					sp_nxt = sp_r + 8'h01;
					wr     = '{1'b1, 1'b1, sp_nxt, pc_r[15:8]};
					pc_ld  = 1'b1;
					tgt    = {op1_r, op2_r}; // [RULE_06]
				end
			end
			BBP_C_RET: begin
				// high byte sits on top; read first, then step down
				if (cyc_r == 3'd1) begin
					pc_ld  = 1'b1;
					tgt    = {rval, pc_r[7:0]}; // [RULE_21]
					sp_nxt = sp_r - 8'h01;
				end else if (cyc_r == 3'd2) begin
					pc_ld  = 1'b1;
					tgt    = {pc_r[15:8], rval}; // [RULE_21]
					sp_nxt = sp_r - 8'h01;
				end
			end
			BBP_C_JIDX: begin
				pc_ld = (cyc_r == 3'd1);
				tgt   = {dph_r, dpl_r} + {8'h00, ACC_I}; // [RULE_08]
			end
			BBP_C_CJA: begin
				if (cyc_r == 3'd2) begin
					carry_we = 1'b1;
					if (op == BBP_OP_CJ_ADIR) begin
						taken   = (ACC_I != rval); // [RULE_10]
						carry_v = (ACC_I < rval);
					end else begin
						taken   = (ACC_I != op1_r); // [RULE_10]
						carry_v = (ACC_I < op1_r);
					end
				end
			end
			BBP_C_CJR: begin
				if (cyc_r == 3'd2) begin
					carry_we = 1'b1;
					taken    = (rd_r != op1_r); // [RULE_10]
					carry_v  = (rd_r < op1_r);
				end
			end
			BBP_C_CJI: begin
				// pointer read in cycle 1, indirect byte in cycle 3
				if (cyc_r == 3'd3) begin
					carry_we = 1'b1;
					taken    = (rval != op1_r); // [RULE_10]
					carry_v  = (rval < op1_r);
				end
			end
			BBP_C_DJR: begin
				if (cyc_r == 3'd1) begin
					wr    = '{1'b1, 1'b0, bank_addr, dec_v};
					taken = (dec_v != 8'h00); // [RULE_11]
				end
			end
			BBP_C_DJD: begin
				if (cyc_r == 3'd2) begin
					wr    = '{1'b1, 1'b0, op1_r, dec_v};
					taken = (dec_v != 8'h00); // [RULE_11]
				end
			end
			BBP_C_PUSH: begin
				if (cyc_r == 3'd1) begin
					sp_nxt = sp_r + 8'h01; // [RULE_17]
					wr     = '{1'b1, 1'b1, sp_nxt, rval}; // [RULE_19]
				end
			end
			BBP_C_POP: begin
				if (cyc_r == 3'd1) begin
					sp_nxt = sp_r - 8'h01; // [RULE_21]
					wr     = '{1'b1, 1'b0, CODE_DATA_I, rval};
				end
			end
			BBP_C_NIBBLE_EXCHANGE: begin
				if (cyc_r == 3'd2) begin
					wr     = '{1'b1, 1'b1, rd_r, {rval[7:4], ACC_I[3:0]}}; // [RULE_18]
					acc_we = 1'b1;
					acc_v  = {ACC_I[7:4], rval[3:0]}; // [RULE_18]
				end
			end
			default: begin
				// no-operation, A5 and foreign opcodes touch nothing
				wr = '0; // [RULE_12]
			end
		endcase
		if (taken) begin
			pc_ld = 1'b1; // [RULE_07]
		end
	end

	////////////////////////////////////////////////////////////////////////
	// memory port and register write routing

	// direct writes to our own registers stay inside
	assign int_hit = wr.we && !wr.ind &&
		(wr.addr == BBP_SP_ADDR || wr.addr == BBP_DPL_ADDR || wr.addr == BBP_DPH_ADDR); // [RULE_15]

	// data and flag strobes are combinational so the next edge commits them
	always_comb begin
		DATA_RADDR_O = raddr;
		DATA_RIND_O  = rind;
		DATA_WR_O    = wr;
		DATA_WR_O.we = wr.we && !int_hit;
		CARRY_WE_O   = carry_we;
		CARRY_O      = carry_v;
		ACC_WE_O     = acc_we;
		ACC_O        = acc_v;
	end

	////////////////////////////////////////////////////////////////////////
	// sequencer

	// taken branches spend exactly one extra cycle after the decision
	assign last = ((cyc_r == dec.ncyc - 3'd1) && !taken) || (cyc_r == dec.ncyc); // [RULE_03]

	// cycle index within the instruction
	always_ff @(posedge REF_CLK_I) begin
		if (!RST_N_I) begin
			cyc_r <= 3'd0;
		end else if (last) begin
			cyc_r <= 3'd0;
		end else begin
			cyc_r <= cyc_r + 3'd1;
		end
	end

	// program counter steps per fetched byte unless a target is loaded
	always_ff @(posedge REF_CLK_I) begin
		if (!RST_N_I) begin
			pc_r <= BBP_PC_RST;
		end else if (pc_ld) begin
			pc_r <= tgt;
		end else if (in_fetch) begin
			pc_r <= pcn;
		end
	end

	// opcode and operand capture as each byte passes
	always_ff @(posedge REF_CLK_I) begin
		if (!RST_N_I) begin
			opc_r <= 8'h00;
			op1_r <= 8'h00;
			op2_r <= 8'h00;
			rd_r  <= 8'h00;
		end else begin
			if (cyc_r == 3'd0) begin
				opc_r <= CODE_DATA_I;
			end
			if (cyc_r == 3'd1) begin
				op1_r <= CODE_DATA_I;
				rd_r  <= rval;
			end
			if (cyc_r == 3'd2) begin
				op2_r <= CODE_DATA_I;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// pointer registers

	// a direct write to the stack pointer wins over its own stepping
	always_ff @(posedge REF_CLK_I) begin
		if (!RST_N_I) begin
			sp_r <= BBP_SP_RST; // [RULE_17]
		end else if (int_hit && wr.addr == BBP_SP_ADDR) begin
			sp_r <= wr.data;
		end else begin
			sp_r <= sp_nxt;
		end
	end

	// data pointer pair, written only as special registers here
	always_ff @(posedge REF_CLK_I) begin
		if (!RST_N_I) begin
			dpl_r <= BBP_DPL_RST; // [RULE_16]
			dph_r <= BBP_DPH_RST;
		end else if (int_hit && wr.addr == BBP_DPL_ADDR) begin
			dpl_r <= wr.data; // [RULE_16]
		end else if (int_hit && wr.addr == BBP_DPH_ADDR) begin
			dph_r <= wr.data; // [RULE_16]
		end
	end

	////////////////////////////////////////////////////////////////////////
	// status outputs

	// fetch marks the opcode cycle; unknown flags opcodes left to other units
	always_ff @(posedge REF_CLK_I) begin
		if (!RST_N_I) begin
			fetch_r   <= 1'b1;
			unknown_r <= 1'b0;
		end else begin
			fetch_r   <= last;
			unknown_r <= (cyc_r == 3'd0) && (dec.cls == BBP_C_OTHER);
		end
	end

	assign CODE_ADDR_O  = pc_r;
	assign STACK_PTR_O  = sp_r;
	assign DATA_POINTER_PAIR_O       = {dph_r, dpl_r};
	assign FETCH_O      = fetch_r;
	assign UNKNOWN_OP_O = unknown_r;

endmodule

/* File: tb/bbp_mem_model.sv */
// partner model: program memory, internal data ram, special registers and carry flag
`timescale 1ns/1ps
module bbp_mem_model import bbp_pkg::*; (
	input  wire logic        clk_i,
	input  wire logic [15:0] code_addr_i,
	output logic [7:0]       code_data_o,
	input  wire logic [7:0]  raddr_i,
	input  wire logic        rind_i,
	output logic [7:0]       rdata_o,
	input  wire bbp_wr_t     wr_i,
	input  wire logic        carry_we_i,
	input  wire logic        carry_i,
	output logic             carry_o
);
	logic [7:0] code [0:65535];
	logic [7:0] ram  [0:255];
	logic [7:0] special_function_register  [128:255];

	////////////////////////////////////////////////////////////////
	// empty memory reads as no-operation so a runaway core stays defined
	initial begin
		for (int i = 0; i < 65536; i++) code[i] = 8'h00;
		for (int i = 0; i < 256; i++) ram[i] = 8'h00;
		for (int i = 128; i < 256; i++) special_function_register[i] = 8'h00;
		carry_o = 1'b0;
	end

	////////////////////////////////////////////////////////////////
	// asynchronous reads; indirect access above 0x7F reaches upper ram
	assign code_data_o = code[code_addr_i];
	assign rdata_o     = (rind_i || !raddr_i[7]) ? ram[raddr_i] : special_function_register[raddr_i];

	// writes and carry land on the clock edge, like the real storage
	always @(posedge clk_i) begin
		if (wr_i.we && (wr_i.ind || !wr_i.addr[7])) ram[wr_i.addr] <= wr_i.data;
		else if (wr_i.we) special_function_register[wr_i.addr] <= wr_i.data;
		if (carry_we_i) carry_o <= carry_i;
	end
endmodule

/* File: tb/bbp_core_checker.sv */
// checker: timing and target relations at the core's ports
`timescale 1ns/1ps
module bbp_core_checker import bbp_pkg::*; (
	input wire logic        REF_CLK_I,
	input wire logic        RST_N_I,
	input wire logic [7:0]  CODE_DATA_I,
	input wire logic [15:0] CODE_ADDR_O,
	input wire logic [7:0]  ACC_I,
	input wire logic        CARRY_I,
	input wire logic        CARRY_WE_O,
	input wire logic        CARRY_O,
	input wire bbp_wr_t     DATA_WR_O,
	input wire logic [7:0]  STACK_PTR_O,
	input wire logic [15:0] DATA_POINTER_PAIR_O,
	input wire logic        FETCH_O,
	input wire logic        UNKNOWN_OP_O
);
	logic [15:0] rel_tgt;

	default clocking @(posedge REF_CLK_I); endclocking
	default disable iff (!RST_N_I);

	// relative target as seen in the offset cycle, where the pc sits on the offset byte
	assign rel_tgt = CODE_ADDR_O + 16'h0001 + {{8{CODE_DATA_I[7]}}, CODE_DATA_I};

	////////////////////////////////////////////////////////////////
	chk_reset_state: assert property ($rose(RST_N_I) |-> FETCH_O && CODE_ADDR_O == 16'h0000
		&& STACK_PTR_O == 8'h07 && DATA_POINTER_PAIR_O == 16'h0000) else $error("bad state after reset");
	chk_push_order: assert property (FETCH_O && CODE_DATA_I == 8'hC0 |=> DATA_WR_O.we
		&& DATA_WR_O.addr == STACK_PTR_O + 8'h01 ##1 FETCH_O) else $error("push write or length wrong");
	chk_nop_quiet: assert property (FETCH_O && (CODE_DATA_I == 8'h00 || CODE_DATA_I == 8'hA5)
		|=> FETCH_O && !UNKNOWN_OP_O && CODE_ADDR_O == $past(CODE_ADDR_O) + 16'h0001)
		else $error("no-operation length wrong");
	chk_carry_write: assert property (FETCH_O && (CODE_DATA_I == 8'hD3 || CODE_DATA_I == 8'hC3)
		|-> CARRY_WE_O && CARRY_O == CODE_DATA_I[4] ##1 FETCH_O) else $error("carry set or clear wrong");
	chk_rel_target: assert property (FETCH_O && (CODE_DATA_I == 8'h80 || (CODE_DATA_I == 8'h40
		&& CARRY_I)) |=> ##2 FETCH_O && CODE_ADDR_O == $past(rel_tgt, 2)) else $error("relative target wrong");
	chk_fall_through: assert property (FETCH_O && CODE_DATA_I == 8'h50 && CARRY_I |=> ##1 FETCH_O
		&& CODE_ADDR_O == $past(CODE_ADDR_O, 2) + 16'h0002) else $error("untaken branch wrong");
	chk_long_target: assert property (FETCH_O && (CODE_DATA_I == 8'h02 || CODE_DATA_I == 8'h12) |=> ##3
		FETCH_O && CODE_ADDR_O == {$past(CODE_DATA_I, 3), $past(CODE_DATA_I, 2)}) else $error("long target wrong");
	chk_index_jump: assert property (FETCH_O && CODE_DATA_I == 8'h73 |=> ##2 FETCH_O
		&& CODE_ADDR_O == $past(DATA_POINTER_PAIR_O, 3) + {8'h00, $past(ACC_I, 3)}) else $error("indexed target wrong");
	chk_return_pop: assert property (FETCH_O && CODE_DATA_I == 8'h22 |=> ##4 FETCH_O
		&& STACK_PTR_O == $past(STACK_PTR_O, 5) - 8'h02) else $error("return pointer wrong");
	chk_unknown_pulse: assert property (FETCH_O && CODE_DATA_I == 8'h04 |=> UNKNOWN_OP_O && FETCH_O
		##1 !UNKNOWN_OP_O) else $error("unknown opcode pulse wrong");
endmodule

bind bbp_core bbp_core_checker chk_inst (.REF_CLK_I(REF_CLK_I), .RST_N_I(RST_N_I), .CODE_DATA_I(CODE_DATA_I),
	.CODE_ADDR_O(CODE_ADDR_O), .ACC_I(ACC_I), .CARRY_I(CARRY_I), .CARRY_WE_O(CARRY_WE_O), .CARRY_O(CARRY_O),
	.DATA_WR_O(DATA_WR_O), .STACK_PTR_O(STACK_PTR_O), .DATA_POINTER_PAIR_O(DATA_POINTER_PAIR_O), .FETCH_O(FETCH_O),
	.UNKNOWN_OP_O(UNKNOWN_OP_O));

/* File: tb/bbp_core_tb.sv */
// testbench: runs a branch and pointer program and checks lengths, targets and state
`timescale 1ns/1ps
module bbp_core_tb;
	import bbp_pkg::*;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [7:0]  acc = 8'h10;
	logic [1:0]  bank = 2'h2;
	logic [7:0]  code_data, rdata, raddr;
	logic [15:0] code_addr, data_pointer_pair;
	logic        rind, carry_we, carry_wv, carry, fetch, unk;
	logic [7:0]  sp;
	bbp_wr_t     wr;
	int          fails = 0;
	int          n_tests = 0;

	always #5 clk = ~clk;

	bbp_core bbp_core_inst (.REF_CLK_I(clk), .RST_N_I(rst_n), .CODE_DATA_I(code_data), .CODE_ADDR_O(code_addr),
		.DATA_RDATA_I(rdata), .DATA_RADDR_O(raddr), .DATA_RIND_O(rind), .DATA_WR_O(wr), .ACC_I(acc),
		.CARRY_I(carry), .BANK_SEL_I(bank), .CARRY_WE_O(carry_we), .CARRY_O(carry_wv), .ACC_WE_O(),
		.ACC_O(), .STACK_PTR_O(sp), .DATA_POINTER_PAIR_O(data_pointer_pair), .FETCH_O(fetch), .UNKNOWN_OP_O(unk));

	bbp_mem_model bbp_mem_model_inst (.clk_i(clk), .code_addr_i(code_addr), .code_data_o(code_data),
		.raddr_i(raddr), .rind_i(rind), .rdata_o(rdata), .wr_i(wr), .carry_we_i(carry_we),
		.carry_i(carry_wv), .carry_o(carry));

	////////////////////////////////////////////////////////////////
	task automatic test_done;
		if (fails == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_tests++;
		if (g !== e) begin
			fails++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask

	// places up to three instruction bytes in program memory
	task automatic pg(input logic [15:0] a, input logic [7:0] b0, input logic [7:0] b1 = 8'h00,
		input logic [7:0] b2 = 8'h00);
		bbp_mem_model_inst.code[a] = b0;
		bbp_mem_model_inst.code[a + 16'h1] = b1;
		bbp_mem_model_inst.code[a + 16'h2] = b2;
	endtask

	// runs one instruction: counts cycles to the next opcode cycle, then checks the new pc
	task automatic step(input int cyc, input logic [15:0] pc);
		int n;
		n = 0;
		do begin
			@(posedge clk);
			#1;
			n++;
		end while (fetch !== 1'b1 && n < 20);
		chk("cycles", 16'(cyc), 16'(n));
		chk("pc", pc, code_addr);
	endtask

	////////////////////////////////////////////////////////////////
	// hang guard, generous against the ~55 cycles the program needs
	initial begin
		repeat (2000) @(posedge clk);
		fails++;
		test_done();
	end

	initial begin
		// let the memory model clear itself first so the program is not wiped
		#1;
		pg(16'h0000, 8'hD3);
		pg(16'h0001, 8'h40, 8'h03);
		pg(16'h0006, 8'h50, 8'h05);
		pg(16'h0008, 8'hA5);
		pg(16'h000A, 8'h80, 8'h10);
		pg(16'h001C, 8'h12, 8'h01, 8'h00);
		pg(16'h0100, 8'hC0, 8'h30);
		pg(16'h0102, 8'hD0, 8'h83);
		pg(16'h0104, 8'h22);
		pg(16'h001F, 8'h41, 8'h80);
		pg(16'h0280, 8'h73);
		pg(16'h5A10, 8'h60, 8'h04);
		pg(16'h5A12, 8'hD2, 8'h07);
		pg(16'h5A14, 8'h10, 8'h07, 8'h03);
		pg(16'h5A1A, 8'hB5, 8'h30, 8'h05);
		pg(16'h5A22, 8'hD8, 8'hFE);
		pg(16'h5A24, 8'h82, 8'h07);
		pg(16'h5A26, 8'h02, 8'h1F, 8'hFF);
		pg(16'h1FFF, 8'h04, 8'hC3);
		bbp_mem_model_inst.ram[8'h30] = 8'h5A;
		bbp_mem_model_inst.ram[8'h10] = 8'h02;
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		#1;
		chk("sp", 16'h0007, {8'h00, sp});
		chk("data_pointer_pair", 16'h0000, data_pointer_pair);
		step(1, 16'h0001);
		step(3, 16'h0006);
		step(2, 16'h0008);
		step(1, 16'h0009);
		step(1, 16'h000A);
		step(3, 16'h001C);
		step(4, 16'h0100);
		chk("sp", 16'h0009, {8'h00, sp});
		chk("ret", 16'h001F, {bbp_mem_model_inst.ram[9], bbp_mem_model_inst.ram[8]});
		step(2, 16'h0102);
		chk("push", 16'h005A, {8'h00, bbp_mem_model_inst.ram[8'h0A]});
		step(2, 16'h0104);
		chk("data_pointer_pair", 16'h5A00, data_pointer_pair);
		step(5, 16'h001F);
		chk("sp", 16'h0007, {8'h00, sp});
		step(3, 16'h0280);
		step(3, 16'h5A10);
		step(2, 16'h5A12);
		step(2, 16'h5A14);
		chk("bit", 16'h0080, {8'h00, bbp_mem_model_inst.ram[8'h20]});
		step(4, 16'h5A1A);
		chk("bit", 16'h0000, {8'h00, bbp_mem_model_inst.ram[8'h20]});
		step(4, 16'h5A22);
		chk("carry", 16'h0001, {15'h0000, carry});
		step(3, 16'h5A22);
		step(2, 16'h5A24);
		chk("r0", 16'h0000, {8'h00, bbp_mem_model_inst.ram[8'h10]});
		step(2, 16'h5A26);
		chk("carry", 16'h0000, {15'h0000, carry});
		step(4, 16'h1FFF);
		step(1, 16'h2000);
		chk("unknown", 16'h0001, {15'h0000, unk});
		step(1, 16'h2001);
		test_done();
	end
endmodule
